// ===== design/fault_debounce.sv
// debounce of the raw output fault flag from the analog block
// assumes the raw flag is synchronous to clk_sys
`timescale 1ns/1ps
module fault_debounce
   import gp_config_two_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic short_delay,
   input wire logic fault_raw,
   output logic fault_result
);

   logic [delay_cnt_width-1:0] count_r, count_nxt;
   logic result_r, result_nxt;
   logic [delay_cnt_width-1:0] limit;

   // limit follows the delay select bit
   assign limit = short_delay ? delay_cnt_width'(short_delay_cycles - 1)
                              : delay_cnt_width'(long_delay_cycles - 1);

   // result changes only after the raw flag has differed for the full delay
   always_comb begin
      count_nxt = count_r;
      result_nxt = result_r;
      if (fault_raw == result_r) begin
         count_nxt = '0;
      end else if (count_r >= limit) begin
         result_nxt = fault_raw; // [R07]
         count_nxt = '0;
      end else begin
         count_nxt = count_r + delay_cnt_width'(1);
      end
   end

   // register the state
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         count_r <= '0;
         result_r <= 1'b0;
      end else begin
         count_r <= count_nxt;
         result_r <= result_nxt;
      end
   end

   assign fault_result = result_r;

endmodule : fault_debounce

// ===== design/general_purpose_config_two_reg.sv
// second general-purpose configuration register with its side effects
// assumes a one-cycle strobe register port and the fault alert level as input
//
// Behaviour
// (R01) reads return the fault alert output level in bit 21, read-only
// (R02) register at address 0x0a, reset 0x0a0200, bits 20:16 read the address
// (R03) bits 14:13: 00 disables voltage comparators, 11 enables, others reserved
// (R04) die temperature comparator stays enabled regardless of the select field
// (R05) host sets the converter internal enable when enabling voltage comparators
// (R06) broadcast load bit makes software load ignore device address bits
// (R07) delay select: 0 gives 25 ms, 1 (reset) gives 6.5 ms fault debounce
// (R08) host writes zero to reserved bits; bit 15 reads zero
`timescale 1ns/1ps
module general_purpose_config_two_reg
   import gp_config_two_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [4:0] reg_addr,
   input wire logic [21:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [21:0] reg_rdata,
   input wire logic fault_alert_level,
   input wire logic output_fault_raw,
   input wire logic software_load_command,
   input wire logic [1:0] load_command_address,
   input wire logic [1:0] device_address,
   output logic output_load_strobe,
   output logic output_fault_result,
   output logic voltage_comparators_enable,
   output logic temperature_comparator_enable,
   output logic irq
);

   // ------------------------------------------------------------
   // request bundle
   // ------------------------------------------------------------
   reg_req_type req;
   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   // ------------------------------------------------------------
   // configuration register
   // ------------------------------------------------------------
   logic [21:0] cfg_r, cfg_nxt;
   config_type cfg;

   // only the writable bits take write data; top bits are never stored
   always_comb begin
      cfg_nxt = cfg_r;
      if (req.wr && req.addr == addr_gp_config_two) begin
         cfg_nxt = req.wdata & writable_mask;
         cfg_nxt[reserved_ro_bit] = 1'b0; // [R08]
      end
   end

   // register the configuration
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cfg_r <= gp_config_two_reset & writable_mask; // [R02]
      end else begin
         cfg_r <= cfg_nxt;
      end
   end

   assign cfg.cmp_select = cfg_r[cmp_hi_bit:cmp_lo_bit];
   assign cfg.broadcast_load_enable = cfg_r[broadcast_bit];
   assign cfg.short_delay = cfg_r[delay_bit];

   // ------------------------------------------------------------
   // comparator control
   // ------------------------------------------------------------
   // reserved codes leave the voltage comparators off
   assign voltage_comparators_enable = (cfg.cmp_select == cmp_enabled); // [R03]
   assign temperature_comparator_enable = 1'b1; // [R04]

   // ------------------------------------------------------------
   // software load decode
   // ------------------------------------------------------------
   logic load_r, load_nxt;

   // address match skipped when broadcast is enabled
   always_comb begin
      load_nxt = software_load_command &&
                 (cfg.broadcast_load_enable || load_command_address == device_address); // [R06]
   end

   // register the load strobe
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         load_r <= 1'b0;
      end else begin
         load_r <= load_nxt;
      end
   end

   assign output_load_strobe = load_r;

   // ------------------------------------------------------------
   // fault debounce
   // ------------------------------------------------------------
   logic fault_result;

   fault_debounce u_debounce (
      .clk_sys(clk_sys),
      .reset(reset),
      .short_delay(cfg.short_delay), // [R07]
      .fault_raw(output_fault_raw),
      .fault_result(fault_result)
   );

   assign output_fault_result = fault_result;

   // ------------------------------------------------------------
   // interrupts
   // ------------------------------------------------------------
   logic [irq_width-1:0] irq_status_r, irq_status_nxt;
   logic [irq_width-1:0] irq_enable_r, irq_enable_nxt;
   logic fault_prev_r, fault_prev_nxt;
   logic [irq_width-1:0] irq_events;

   // events: debounced fault rising, falling, and an accepted load
   always_comb begin
      irq_events = '0;
      irq_events[irq_fault_set] = fault_result & ~fault_prev_r;
      irq_events[irq_fault_clear] = ~fault_result & fault_prev_r;
      irq_events[irq_load] = load_nxt;
      fault_prev_nxt = fault_result;
      irq_enable_nxt = irq_enable_r;
      irq_status_nxt = irq_status_r;
      if (req.wr && req.addr == addr_irq_enable) begin
         irq_enable_nxt = req.wdata[irq_width-1:0];
      end
      if (req.wr && req.addr == addr_irq_clear) begin
         irq_status_nxt = irq_status_r & ~req.wdata[irq_width-1:0];
      end
      irq_status_nxt = irq_status_nxt | irq_events; // set wins over clear
   end

   // register interrupt state
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         irq_status_r <= '0;
         irq_enable_r <= '0;
         fault_prev_r <= 1'b0;
      end else begin
         irq_status_r <= irq_status_nxt;
         irq_enable_r <= irq_enable_nxt;
         fault_prev_r <= fault_prev_nxt;
      end
   end

   assign irq = |(irq_status_r & irq_enable_r);

   // ------------------------------------------------------------
   // read data
   // ------------------------------------------------------------
   logic [21:0] rdata_r, rdata_nxt;

   // read data stands only in the cycle after the read strobe
   always_comb begin
      rdata_nxt = '0;
      if (req.rd) begin
         unique case (req.addr)
            addr_gp_config_two: begin
               rdata_nxt = cfg_r;
               rdata_nxt[fault_pin_bit] = fault_alert_level; // [R01]
               rdata_nxt[addr_hi_bit:addr_lo_bit] = addr_gp_config_two; // [R02]
            end
            addr_irq_status: rdata_nxt[irq_width-1:0] = irq_status_r;
            addr_irq_enable: rdata_nxt[irq_width-1:0] = irq_enable_r;
            default: rdata_nxt = '0;
         endcase
      end
   end

   // register the read data
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rdata_r <= '0;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata = rdata_r;

endmodule : general_purpose_config_two_reg

// ===== shared/gp_config_two_pkg.sv
// package for the second general-purpose configuration register block
// assumes a single 50 MHz system clock and a plain register port
package gp_config_two_pkg;

   // ------------------------------------------------------------
   // register map and field layout
   // ------------------------------------------------------------
   localparam logic [4:0] addr_gp_config_two = 5'h0a;
   localparam logic [4:0] addr_irq_status = 5'h1c;
   localparam logic [4:0] addr_irq_enable = 5'h1d;
   localparam logic [4:0] addr_irq_clear = 5'h1e;
   localparam logic [21:0] gp_config_two_reset = 22'h0a0200;
   localparam int fault_pin_bit = 21;
   localparam int addr_hi_bit = 20;
   localparam int addr_lo_bit = 16;
   localparam int reserved_ro_bit = 15;
   localparam int cmp_hi_bit = 14;
   localparam int cmp_lo_bit = 13;
   localparam int broadcast_bit = 10;
   localparam int delay_bit = 9;
   localparam logic [1:0] cmp_disabled = 2'h0;
   localparam logic [1:0] cmp_enabled = 2'h3;
   localparam logic [21:0] writable_mask = 22'h007fff;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int clk_hz = 50_000_000;
   localparam int long_delay_us = 25_000;
   localparam int short_delay_us = 6_500;
   localparam int long_delay_cycles = long_delay_us * (clk_hz / 1_000_000);
   localparam int short_delay_cycles = short_delay_us * (clk_hz / 1_000_000);
   localparam int delay_cnt_width = 21;

   // ------------------------------------------------------------
   // interrupt bit positions
   // ------------------------------------------------------------
   localparam int irq_width = 3;
   localparam int irq_fault_set = 0;
   localparam int irq_fault_clear = 1;
   localparam int irq_load = 2;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic [4:0] addr;
      logic [21:0] wdata;
      logic wr;
      logic rd;
   } reg_req_type;

   typedef struct packed {
      logic [1:0] cmp_select;
      logic broadcast_load_enable;
      logic short_delay;
   } config_type;

endpackage : gp_config_two_pkg

// ===== tb/gp_config_two_assertions.sv
// checker for the second general-purpose configuration register block
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
module gp_config_two_assertions
   import gp_config_two_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [4:0] reg_addr,
   input wire logic [21:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [21:0] reg_rdata,
   input wire logic fault_alert_level,
   input wire logic output_fault_raw,
   input wire logic software_load_command,
   input wire logic [1:0] load_command_address,
   input wire logic [1:0] device_address,
   input wire logic output_load_strobe,
   input wire logic output_fault_result,
   input wire logic voltage_comparators_enable,
   input wire logic temperature_comparator_enable
);
   // ------------------------------------------------------------
   // shadow of the writable field bits
   // ------------------------------------------------------------
   logic [14:0] cfg_r;
   always_ff @(posedge clk_sys) begin
      if (reset) cfg_r <= 15'h0200;
      else if (reg_wr && reg_addr == addr_gp_config_two) cfg_r <= reg_wdata[14:0];
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   sequence cfg_read;
      reg_rd && reg_addr == addr_gp_config_two;
   endsequence
   sequence load_hit;
      software_load_command && (cfg_r[10] || load_command_address == device_address);
   endsequence
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   read_word_a: assert property (cfg_read |=>
      reg_rdata == {$past(fault_alert_level), addr_gp_config_two, 1'b0, $past(cfg_r)})
      else $error("config read word wrong");
   read_fault_a: assert property (cfg_read |=>
      reg_rdata[21] == $past(fault_alert_level)) else $error("fault level bit wrong");
   rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 22'h000000)
      else $error("read data outside read slot");
   cmp_enable_a: assert property (voltage_comparators_enable == (cfg_r[14:13] == 2'h3))
      else $error("comparator enable wrong");
   temp_on_a: assert property (temperature_comparator_enable)
      else $error("temperature comparator off");
   load_take_a: assert property (load_hit |=> output_load_strobe)
      else $error("load command not taken");
   load_refuse_a: assert property (!software_load_command ||
      (!cfg_r[10] && load_command_address != device_address) |=> !output_load_strobe)
      else $error("load strobe without command");
   debounce_a: assert property ($changed(output_fault_result) |->
      $past(output_fault_raw, 8) == output_fault_result) else $error("fault result glitched");
endmodule : gp_config_two_assertions

bind general_purpose_config_two_reg gp_config_two_assertions chk (.clk_sys, .reset,
   .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .fault_alert_level,
   .output_fault_raw, .software_load_command, .load_command_address, .device_address,
   .output_load_strobe, .output_fault_result, .voltage_comparators_enable,
   .temperature_comparator_enable);

// ===== tb/host_model.sv
// host side of the register port: one-cycle write and read strobes
// assumes read data stand only in the cycle after the read strobe
`timescale 1ns/1ps
module host_model (
   input wire logic clk_sys,
   output logic [4:0] reg_addr,
   output logic [21:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [21:0] reg_rdata
);
   initial begin
      reg_addr = 5'h00;
      reg_wdata = 22'h000000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // one write cycle; idle bus shows inverted values, callers zero reserved bits
   task wr(input logic [4:0] a, input logic [21:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask : wr
   // one read cycle, data taken in the following cycle
   task rd(input logic [4:0] a, output logic [21:0] q);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      @(negedge clk_sys);
      q = reg_rdata;
   endtask : rd
endmodule : host_model

// ===== tb/tb.sv
// testbench for the second general-purpose configuration register block
// assumes the host model drives the register port
`timescale 1ns/1ps
module tb;
   import gp_config_two_pkg::*;
   logic clk_sys = 1'b0, reset = 1'b1, fault_lvl = 1'b0, raw = 1'b0, cmd = 1'b0;
   logic [1:0] lca = 2'h0, dev = 2'h1;
   logic [4:0] addr;
   logic [21:0] wdata, rdata, q, d;
   logic wr, rd, strobe, fres, vce, tce, irq;
   int errors = 0, comparisons = 0, seed = 66963;
   always #10 clk_sys = ~clk_sys;
   host_model host (.clk_sys, .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
      .reg_rd(rd), .reg_rdata(rdata));
   general_purpose_config_two_reg dut (.clk_sys, .reset, .reg_addr(addr),
      .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
      .fault_alert_level(fault_lvl), .output_fault_raw(raw), .software_load_command(cmd),
      .load_command_address(lca), .device_address(dev), .output_load_strobe(strobe),
      .output_fault_result(fres), .voltage_comparators_enable(vce),
      .temperature_comparator_enable(tce), .irq(irq));
   // expected config word from fault level and written data
   function automatic logic [21:0] exp_word(input logic f, input logic [21:0] v);
      return {f, 5'h0a, 1'b0, v[14:0]};
   endfunction : exp_word
   task chk(input logic [21:0] got, input logic [21:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // one load command cycle, strobe looked at in the next cycle
   task load(input logic [1:0] a, input logic e);
      @(posedge clk_sys);
      cmd <= 1'b1;
      lca <= a;
      @(posedge clk_sys);
      cmd <= 1'b0;
      lca <= ~a;
      @(negedge clk_sys);
      chk({21'h0, strobe}, {21'h0, e});
   endtask : load
   task finish_test;
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : finish_test
   initial begin
      #100000;
      errors++;
      finish_test();
   end
   initial begin
      repeat (5) @(posedge clk_sys);
      reset <= 1'b0;
      host.rd(addr_gp_config_two, q);
      chk(q, 22'h0a0200);
      // every comparator code with random fields, read-only top bits random
      for (int i = 0; i < 4; i++) begin
         d = $random(seed);
         d = d & 22'h3f6600; // host keeps reserved bits zero, read-only top bits random
         d[14:13] = i[1:0];
         fault_lvl <= i[0];
         host.wr(addr_gp_config_two, d);
         host.rd(addr_gp_config_two, q);
         chk(q, exp_word(i[0], d));
         chk({20'h0, vce, tce}, {20'h0, i == 3, 1'b1});
      end
      host.rd(5'h05, q);
      chk(q, 22'h000000);
      host.wr(addr_irq_enable, 22'h000004);
      host.wr(addr_gp_config_two, 22'h000200);
      load(2'h2, 1'b0);
      load(2'h1, 1'b1);
      chk({21'h0, irq}, 22'h000001);
      host.rd(addr_irq_status, q);
      chk(q, 22'h000004);
      host.wr(addr_irq_clear, 22'h000004);
      @(negedge clk_sys);
      chk({21'h0, irq}, 22'h000000);
      host.wr(addr_gp_config_two, 22'h000400);
      load(2'h2, 1'b1);
      // short fault glitch must not reach the result
      raw <= 1'b1;
      repeat (50) @(posedge clk_sys);
      raw <= 1'b0;
      @(negedge clk_sys);
      chk({21'h0, fres}, 22'h000000);
      finish_test();
   end
endmodule : tb
